/* File: hw/brt_engine.sv */
// Boundary run-test engine: scan registers, run-test operations, shadows and pins
`timescale 1ns/1ps
module brt_engine
	import brt_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic             tdi,
	input  wire logic             tap_run_idle,
	input  wire logic             tap_capture_dr,
	input  wire logic             tap_shift_dr,
	input  wire logic             tap_update_dr,
	input  wire logic             run_selected_test_instr,
	input  wire logic             toggle_outputs_instr,
	input  wire logic             control_scan_instr,
	input  wire logic             boundary_read_instr,
	input  wire logic [PIN_W-1:0] a_pin_in,
	input  wire logic [PIN_W-1:0] b_pin_in,
	output logic                  tdo,
	output logic                  test_mode,
	output logic [PIN_W-1:0]      a_pin_out,
	output logic [PIN_W-1:0]      a_pin_oe,
	output logic [PIN_W-1:0]      b_pin_out,
	output logic [PIN_W-1:0]      b_pin_oe,
	output logic [PIN_W-1:0]      core_a_in,
	output logic [PIN_W-1:0]      core_b_in,
	output logic [CTRL_W-1:0]     run_test_control_register,
	output logic                  run_active
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [CHAIN_LEN-1:0] chain;
		logic [CTRL_W-1:0]    ctrl_shift;
		logic [CTRL_W-1:0]    ctrl_hold;
		logic                 bypass;
		logic                 tdo;
		logic                 in_pend;
		logic                 out_pend;
		logic [PIN_W-1:0]     a_in_sh;
		logic [PIN_W-1:0]     a_out_sh;
		logic [PIN_W-1:0]     b_in_sh;
		logic [PIN_W-1:0]     b_out_sh;
		logic [PIN_W-1:0]     a_oe;
		logic [PIN_W-1:0]     b_oe;
		logic                 test_mode;
		logic                 run_active;
	} brt_state_t;

	brt_state_t st_reg;
	brt_state_t st_next;

	brt_step_if sif ();

	// ==========================================================
	// Direction decode from the enable cells
	logic en1a;
	logic en1b;
	logic en2a;
	logic en2b;
	logic dir_ok;
	logic a_to_b;
	logic run_ok;
	logic toggle_ok;
	logic chain_sel;
	logic ctrl_sel;
	brt_op_t op_dec;

	assign en1a = st_reg.chain[OE1A_POS];
	assign en1b = st_reg.chain[OE1B_POS];
	assign en2a = st_reg.chain[OE2A_POS];
	assign en2b = st_reg.chain[OE2B_POS];

	// One direction per byte, same direction for both bytes
	assign dir_ok = (en1a != en1b) && (en1a == en2a) && (en1b == en2b);
	// A-to-B flow: the B drivers are enabled, A is the receiving side
	assign a_to_b = en1b;

	// Operation runs only under run-test in idle with a legal direction
	assign run_ok    = run_selected_test_instr & tap_run_idle & dir_ok;
	assign toggle_ok = toggle_outputs_instr & tap_run_idle & dir_ok;

	// Data register selection; everything else sees the bypass bit
	assign chain_sel = boundary_read_instr;
	assign ctrl_sel  = control_scan_instr;

	// ==========================================================
	// Opcode decode; bit 2 only matters for the 18-bit pair
	always_comb begin
		case (st_reg.ctrl_hold[OPC_LO+1:OPC_LO])
			2'h0: op_dec = BRT_OP_SAMPLE_TOGGLE;
			2'h1: op_dec = BRT_OP_PATTERN36;
			2'h2: op_dec = BRT_OP_SIGNATURE36;
			2'h3: begin
				if (st_reg.ctrl_hold[OPC_HI]) begin
					op_dec = BRT_OP_SIG_COUNT18;
				end else begin
					op_dec = BRT_OP_SIG_PATTERN18;
				end
			end
			default: op_dec = BRT_OP_SAMPLE_TOGGLE;
		endcase
	end

	// ==========================================================
	// Step calculator hookup; cell order follows flow direction
	always_comb begin
		if (toggle_outputs_instr) begin
			sif.op = BRT_OP_SAMPLE_TOGGLE;
		end else begin
			sif.op = op_dec;
		end
		sif.mask = st_reg.ctrl_hold[MASK_HI:MASK_LO];
		if (a_to_b) begin
			sif.cur_in  = st_reg.chain[A_IN_LO+PIN_W-1:A_IN_LO];
			sif.cur_out = st_reg.chain[B_OUT_LO+PIN_W-1:B_OUT_LO];
			sif.pins    = a_pin_in;
		end else begin
			sif.cur_in  = st_reg.chain[B_IN_LO+PIN_W-1:B_IN_LO];
			sif.cur_out = st_reg.chain[A_OUT_LO+PIN_W-1:A_OUT_LO];
			sif.pins    = b_pin_in;
		end
	end

	brt_step_unit u_step (
		.sif (sif.step)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		st_next = st_reg;

		// Serial output follows the selected register's last bit
		if (tap_shift_dr) begin
			if (chain_sel) begin
				st_next.tdo = st_reg.chain[0];
			end else if (ctrl_sel) begin
				st_next.tdo = st_reg.ctrl_shift[0];
			end else begin
				st_next.tdo = st_reg.bypass;
			end
		end

		// Bypass bit: zero on capture, takes tdi on shift, holds otherwise
		if (!chain_sel && !ctrl_sel) begin
			if (tap_capture_dr) begin
				st_next.bypass = BYP_CAPT;
			end else if (tap_shift_dr) begin
				st_next.bypass = tdi;
			end
		end

		// Control register: capture leaves it alone, update makes it live
		if (ctrl_sel) begin
			if (tap_shift_dr) begin
				st_next.ctrl_shift = {tdi, st_reg.ctrl_shift[CTRL_W-1:1]};
			end else if (tap_update_dr) begin
				st_next.ctrl_hold = st_reg.ctrl_shift;
			end
		end

		// Boundary chain scan is how the controller seeds operations
		if (chain_sel && tap_shift_dr) begin
			st_next.chain = {tdi, st_reg.chain[CHAIN_LEN-1:1]};
		end

		// Shadows follow one cycle after a step, standing in for the falling edge
		st_next.in_pend  = 1'b0;
		st_next.out_pend = 1'b0;

		if (run_ok) begin
			// Control cells 87..72 are never touched here
			if (a_to_b) begin
				st_next.chain[A_IN_LO+PIN_W-1:A_IN_LO]   = sif.nxt_in;
				st_next.chain[B_OUT_LO+PIN_W-1:B_OUT_LO] = sif.nxt_out;
			end else begin
				st_next.chain[B_IN_LO+PIN_W-1:B_IN_LO]   = sif.nxt_in;
				st_next.chain[A_OUT_LO+PIN_W-1:A_OUT_LO] = sif.nxt_out;
			end
			st_next.in_pend = 1'b1;
			// Signature-only mode keeps the driven values still
			st_next.out_pend = (op_dec != BRT_OP_SIGNATURE36);
		end else if (toggle_ok) begin
			// Input cells hold; pins are not sampled
			if (a_to_b) begin
				st_next.chain[B_OUT_LO+PIN_W-1:B_OUT_LO] = sif.nxt_out;
			end else begin
				st_next.chain[A_OUT_LO+PIN_W-1:A_OUT_LO] = sif.nxt_out;
			end
			st_next.out_pend = 1'b1;
		end

		// Input shadows feed the core
		if (st_reg.in_pend) begin
			if (a_to_b) begin
				st_next.a_in_sh = st_reg.chain[A_IN_LO+PIN_W-1:A_IN_LO];
			end else begin
				st_next.b_in_sh = st_reg.chain[B_IN_LO+PIN_W-1:B_IN_LO];
			end
		end

		// Output shadows drive the pins
		if (st_reg.out_pend) begin
			if (a_to_b) begin
				st_next.b_out_sh = st_reg.chain[B_OUT_LO+PIN_W-1:B_OUT_LO];
			end else begin
				st_next.a_out_sh = st_reg.chain[A_OUT_LO+PIN_W-1:A_OUT_LO];
			end
		end

		// Update on the chain loads every shadow at once
		if (chain_sel && tap_update_dr) begin
			st_next.a_in_sh  = st_reg.chain[A_IN_LO+PIN_W-1:A_IN_LO];
			st_next.a_out_sh = st_reg.chain[A_OUT_LO+PIN_W-1:A_OUT_LO];
			st_next.b_in_sh  = st_reg.chain[B_IN_LO+PIN_W-1:B_IN_LO];
			st_next.b_out_sh = st_reg.chain[B_OUT_LO+PIN_W-1:B_OUT_LO];
		end

		// Test mode under the toggle and run-test instructions
		st_next.test_mode  = toggle_outputs_instr | run_selected_test_instr;
		st_next.run_active = run_ok;

		// Enable cells steer drivers per byte even while the data cells run
		st_next.a_oe = {{9{en2a}}, {9{en1a}}} & {PIN_W{st_next.test_mode}};
		st_next.b_oe = {{9{en2b}}, {9{en1b}}} & {PIN_W{st_next.test_mode}};
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg.chain      <= CHAIN_RST;
			st_reg.ctrl_shift <= CTRL_RST;
			st_reg.ctrl_hold  <= CTRL_RST;
			st_reg.bypass     <= BYP_CAPT;
			st_reg.tdo        <= 1'b0;
			st_reg.in_pend    <= 1'b0;
			st_reg.out_pend   <= 1'b0;
			st_reg.a_in_sh    <= PIN_RST;
			st_reg.a_out_sh   <= PIN_RST;
			st_reg.b_in_sh    <= PIN_RST;
			st_reg.b_out_sh   <= PIN_RST;
			st_reg.a_oe       <= PIN_RST;
			st_reg.b_oe       <= PIN_RST;
			st_reg.test_mode  <= 1'b0;
			st_reg.run_active <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign tdo                       = st_reg.tdo;
	assign test_mode                 = st_reg.test_mode;
	assign a_pin_out                 = st_reg.a_out_sh;
	assign a_pin_oe                  = st_reg.a_oe;
	assign b_pin_out                 = st_reg.b_out_sh;
	assign b_pin_oe                  = st_reg.b_oe;
	assign core_a_in                 = st_reg.a_in_sh;
	assign core_b_in                 = st_reg.b_in_sh;
	assign run_test_control_register = st_reg.ctrl_hold;
	assign run_active                = st_reg.run_active;

endmodule

/* File: hw/brt_pkg.sv */
// Shared constants and types for the boundary run-test engine
package brt_pkg;

	// ==========================================================
	// Chain layout
	localparam int CHAIN_LEN   = 88;
	localparam int PIN_W       = 18;
	localparam int CTRL_W      = 21;
	localparam int SEL_W       = 36;

	// Control cells, excluded from every algorithm
	localparam int CTRL_CELL_HI = 87;
	localparam int CTRL_CELL_LO = 72;
	localparam int OE1A_POS     = 87;
	localparam int OE1B_POS     = 86;
	localparam int OE2A_POS     = 85;
	localparam int OE2B_POS     = 84;

	// Data cell groups, 18 cells each
	localparam int A_IN_LO  = 54;
	localparam int A_OUT_LO = 36;
	localparam int B_IN_LO  = 18;
	localparam int B_OUT_LO = 0;

	// ==========================================================
	// Run-test control register fields
	localparam int OPC_HI  = 2;
	localparam int OPC_LO  = 0;
	localparam int MASK_HI = 20;
	localparam int MASK_LO = 3;

	// ==========================================================
	// Feedback tap positions (maximal-length)
	localparam int TAP36_HI = 35;
	localparam int TAP36_LO = 24;
	localparam int TAP18_HI = 17;
	localparam int TAP18_LO = 10;

	// ==========================================================
	// Reset values
	localparam logic [CHAIN_LEN-1:0] CHAIN_RST = 88'h0;
	localparam logic [CTRL_W-1:0]    CTRL_RST  = 21'h0;
	localparam logic [PIN_W-1:0]     PIN_RST   = 18'h0;
	localparam logic                 BYP_CAPT  = 1'b0;

	// Decoded operations of the control register
	typedef enum logic [2:0] {
		BRT_OP_SAMPLE_TOGGLE,
		BRT_OP_PATTERN36,
		BRT_OP_SIGNATURE36,
		BRT_OP_SIG_PATTERN18,
		BRT_OP_SIG_COUNT18
	} brt_op_t;

endpackage

/* File: hw/brt_step_if.sv */
// Carrier between the engine core and its step calculator
`timescale 1ns/1ps
interface brt_step_if;
	import brt_pkg::*;

	brt_op_t            op;
	logic [PIN_W-1:0]   cur_in;
	logic [PIN_W-1:0]   cur_out;
	logic [PIN_W-1:0]   pins;
	logic [PIN_W-1:0]   mask;
	logic [PIN_W-1:0]   nxt_in;
	logic [PIN_W-1:0]   nxt_out;

	modport core (
		output op,
		output cur_in,
		output cur_out,
		output pins,
		output mask,
		input  nxt_in,
		input  nxt_out
	);

	modport step (
		input  op,
		input  cur_in,
		input  cur_out,
		input  pins,
		input  mask,
		output nxt_in,
		output nxt_out
	);

endinterface

/* File: hw/brt_step_unit.sv */
// Next-value calculator for the selected cells, one step per run cycle
`timescale 1ns/1ps
module brt_step_unit
	import brt_pkg::*;
(
	brt_step_if.step sif
);

	logic [PIN_W-1:0] data_m;
	logic [SEL_W-1:0] whole;
	logic [SEL_W-1:0] whole_sh;
	logic [PIN_W-1:0] in_sh;
	logic [PIN_W-1:0] out_sh;

	// ==========================================================
	// Per-input masking of the signature
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_mask
			assign data_m[gi] = sif.pins[gi] & ~sif.mask[gi];
		end
	endgenerate

	// Shifted registers; an all-zero seed stays all zero
	assign whole    = {sif.cur_out, sif.cur_in};
	assign whole_sh = {whole[SEL_W-2:0], whole[TAP36_HI] ^ whole[TAP36_LO]};
	assign in_sh    = {sif.cur_in[PIN_W-2:0], sif.cur_in[TAP18_HI] ^ sif.cur_in[TAP18_LO]};
	assign out_sh   = {sif.cur_out[PIN_W-2:0], sif.cur_out[TAP18_HI] ^ sif.cur_out[TAP18_LO]};

	// Operation select
	always_comb begin
		sif.nxt_in  = sif.cur_in;
		sif.nxt_out = sif.cur_out;
		case (sif.op)
			BRT_OP_SAMPLE_TOGGLE: begin
				sif.nxt_in  = sif.pins;
				sif.nxt_out = ~sif.cur_out;
			end
			BRT_OP_PATTERN36: begin
				sif.nxt_in  = whole_sh[PIN_W-1:0];
				sif.nxt_out = whole_sh[SEL_W-1:PIN_W];
			end
			BRT_OP_SIGNATURE36: begin
				sif.nxt_in  = whole_sh[PIN_W-1:0] ^ data_m;
				sif.nxt_out = whole_sh[SEL_W-1:PIN_W];
			end
			BRT_OP_SIG_PATTERN18: begin
				sif.nxt_in  = in_sh ^ data_m;
				sif.nxt_out = out_sh;
			end
			BRT_OP_SIG_COUNT18: begin
				sif.nxt_in  = in_sh ^ data_m;
				sif.nxt_out = sif.cur_out + 18'h00001;
			end
			default: begin
				sif.nxt_in  = sif.cur_in;
				sif.nxt_out = sif.cur_out;
			end
		endcase
	end

endmodule

/* File: tb/brt_tap_ctrl.sv */
// Boundary-scan controller model that drives the scan access port
`timescale 1ns/1ps
module brt_tap_ctrl (
	input  wire logic ref_clk,
	input  wire logic tdo,
	output logic      tdi,
	output logic      tap_run_idle,
	output logic      tap_capture_dr,
	output logic      tap_shift_dr,
	output logic      tap_update_dr
);
	// ==========================================================
	// Port idle at time zero
	initial begin
		tdi            = 1'b1;
		tap_run_idle   = 1'b0;
		tap_capture_dr = 1'b0;
		tap_shift_dr   = 1'b0;
		tap_update_dr  = 1'b0;
	end

	// One-cycle capture or update pulse
	task automatic pulse(input bit upd);
		@(posedge ref_clk);
		tap_update_dr  <= upd;
		tap_capture_dr <= !upd;
		@(posedge ref_clk);
		tap_update_dr  <= 1'b0;
		tap_capture_dr <= 1'b0;
	endtask

	// Shift n bits LSB first; a shift taken at one edge shows on tdo
	// only after that edge, so each bit is read one edge later still
	task automatic scan(input int n, input logic [87:0] din, output logic [87:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			if (i > 1) begin
				dout[i-2] = tdo;
			end
			tap_shift_dr <= 1'b1;
			tdi          <= din[i];
		end
		@(posedge ref_clk);
		dout[n-2] = tdo;
		tap_shift_dr <= 1'b0;
		// Released line shows the inverse, never a stale copy
		tdi          <= ~din[n-1];
		@(posedge ref_clk);
		dout[n-1] = tdo;
	endtask

	// Hold Run-Test/Idle for exactly n sampling edges
	task automatic run(input int n);
		@(posedge ref_clk);
		tap_run_idle <= 1'b1;
		repeat (n) @(posedge ref_clk);
		tap_run_idle <= 1'b0;
	endtask
endmodule

/* File: tb/brt_engine_sva.sv */
// Port-level assertions for the boundary run-test engine
`timescale 1ns/1ps
module brt_engine_sva
	import brt_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              arst_n,
	input wire logic              tdi,
	input wire logic              tap_run_idle,
	input wire logic              tap_capture_dr,
	input wire logic              tap_shift_dr,
	input wire logic              tap_update_dr,
	input wire logic              run_selected_test_instr,
	input wire logic              toggle_outputs_instr,
	input wire logic              control_scan_instr,
	input wire logic              boundary_read_instr,
	input wire logic [PIN_W-1:0]  a_pin_in,
	input wire logic [PIN_W-1:0]  b_pin_in,
	input wire logic              tdo,
	input wire logic              test_mode,
	input wire logic [PIN_W-1:0]  a_pin_out,
	input wire logic [PIN_W-1:0]  a_pin_oe,
	input wire logic [PIN_W-1:0]  b_pin_out,
	input wire logic [PIN_W-1:0]  b_pin_oe,
	input wire logic [PIN_W-1:0]  core_a_in,
	input wire logic [PIN_W-1:0]  core_b_in,
	input wire logic [CTRL_W-1:0] run_test_control_register,
	input wire logic              run_active
);
	// ==========================================================
	// Single test-clock domain
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	// Steps only happen from idle under a stepping instruction
	AST_RUN_IDLE: assert property (run_active |-> $past(tap_run_idle && (run_selected_test_instr || toggle_outputs_instr)))
		else $error("step taken outside run-test idle");
	AST_TEST_MODE: assert property (test_mode == $past(run_selected_test_instr || toggle_outputs_instr))
		else $error("test mode does not follow instruction");
	AST_CTRL_HOLD: assert property (!$past(tap_update_dr && control_scan_instr) |-> $stable(run_test_control_register))
		else $error("control register changed without update");
	AST_BYP_ZERO: assert property ($fell(tap_capture_dr) && toggle_outputs_instr ##1 tap_shift_dr |=> tdo == BYP_CAPT)
		else $error("bypass did not capture zero");
	// Signature mode must not disturb driven values
	AST_PSA_FROZEN: assert property (run_active && run_test_control_register[1:0] == 2'b10 |=> $stable(a_pin_out) && $stable(b_pin_out))
		else $error("output shadows moved in signature mode");
	AST_TOGGLE_CORE: assert property (toggle_outputs_instr [*4] |-> $stable(core_a_in) && $stable(core_b_in))
		else $error("core inputs moved under toggle");
	AST_OE_GATED: assert property (!test_mode && !$past(test_mode) |-> a_pin_oe == '0 && b_pin_oe == '0)
		else $error("pins driven outside test mode");
	AST_OE_BYTE: assert property (a_pin_oe[17:9] inside {9'h000, 9'h1FF} && b_pin_oe[8:0] inside {9'h000, 9'h1FF})
		else $error("byte enable split inside a byte");
	AST_COUNT_MOVES: assert property (run_active && run_test_control_register[2:0] == 3'b111 |=> !$stable({a_pin_out, b_pin_out}))
		else $error("counter shadow did not advance");
endmodule

bind brt_engine brt_engine_sva brt_engine_sva_i (.*);

/* File: tb/testbench.sv */
// Self-checking bench for the boundary run-test engine
`timescale 1ns/1ps
module testbench;
	import brt_pkg::*;

	// ==========================================================
	// Signals
	logic                ref_clk, arst_n, tdi, tdo, test_mode, run_active;
	logic                tap_run_idle, tap_capture_dr, tap_shift_dr, tap_update_dr;
	logic                run_selected_test_instr, toggle_outputs_instr;
	logic                control_scan_instr, boundary_read_instr;
	logic [PIN_W-1:0]    a_pin_in, b_pin_in, a_pin_out, a_pin_oe, b_pin_out, b_pin_oe;
	logic [PIN_W-1:0]    core_a_in, core_b_in;
	logic [CTRL_W-1:0]   run_test_control_register;
	logic [87:0]         rd;
	int                  errors, n_compared;
	// Enable cells 1A,1B,2A,2B = 0,1,0,1: one direction, A receiving
	localparam logic [3:0]  DIR_OK = 4'h5;
	localparam logic [2:0]  G_OP   [6] = '{3'b101, 3'b011, 3'b110, 3'b110, 3'b010, 3'b010};
	localparam logic [17:0] G_MASK [6] = '{18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h00000, 18'h20000, 18'h1FFFF};
	localparam logic [17:0] G_PINS [6] = '{18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h20000, 18'h20000};
	localparam logic        G_ZERO [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

	brt_engine brt_engine_i (.*);
	brt_tap_ctrl brt_tap_ctrl_i (.*);

	// ==========================================================
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Helpers
	task automatic check(input logic [87:0] got, input logic [87:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	task automatic set_instr(input logic [3:0] code);
		@(posedge ref_clk);
		{run_selected_test_instr, toggle_outputs_instr, control_scan_instr, boundary_read_instr} <= code;
	endtask
	task automatic load_ctrl(input logic [CTRL_W-1:0] w, output logic [87:0] old);
		set_instr(4'h2);
		brt_tap_ctrl_i.pulse(1'b0);
		brt_tap_ctrl_i.scan(CTRL_W, {67'h0, w}, old);
		brt_tap_ctrl_i.pulse(1'b1);
		@(posedge ref_clk);
		#1;
	endtask
	// Capture leaves the chain alone, so the old contents come back out
	task automatic load_chain(input logic [87:0] s, output logic [87:0] old);
		set_instr(4'h1);
		brt_tap_ctrl_i.pulse(1'b0);
		brt_tap_ctrl_i.scan(CHAIN_LEN, s, old);
	endtask
	task automatic steps(input logic [3:0] code, input int n);
		set_instr(code);
		brt_tap_ctrl_i.run(n);
		set_instr(4'h0);
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	task automatic run_op(input logic [CTRL_W-1:0] w, input int n);
		logic [87:0] tmp;
		load_ctrl(w, tmp);
		steps(4'h8, n);
	endtask
	task automatic done(input string name);
		$display("test %s done, errors %0d", name, errors);
	endtask
	task automatic stop_test();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs a few thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end

	// ==========================================================
	// Test sequence
	initial begin
		errors = 0;
		n_compared = 0;
		arst_n = 1'b0;
		{run_selected_test_instr, toggle_outputs_instr, control_scan_instr, boundary_read_instr} = 4'h0;
		a_pin_in = 18'h00000;
		b_pin_in = 18'h3C3C3;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		check({64'h0, tdo, test_mode, run_active, run_test_control_register}, '0, "reset state");
		// Control register swap: old word comes out unchanged
		load_ctrl(21'h1ABCD5, rd);
		check(rd, '0, "control reset value");
		load_ctrl(21'h0A5A5A, rd);
		check(rd, {67'h0, 21'h1ABCD5}, "control capture kept");
		check({67'h0, run_test_control_register}, {67'h0, 21'h0A5A5A}, "control update");
		done("control");
		// Bypass under toggle, away from idle
		set_instr(4'h4);
		brt_tap_ctrl_i.pulse(1'b0);
		brt_tap_ctrl_i.scan(2, 88'h3, rd);
		check(rd, {86'h0, 1'b1, BYP_CAPT}, "bypass capture");
		done("bypass");
		// Count wraps through all ones
		load_chain({DIR_OK, 12'h0, 54'h0, 18'h3FFFE}, rd);
		run_op({18'h3FFFF, 3'b111}, 3);
		check({70'h0, b_pin_out}, 88'h1, "count on pins");
		load_chain({DIR_OK, 12'h0, 54'h0, 18'h3FFFE}, rd);
		check(rd, {DIR_OK, 12'h0, 54'h0, 18'h00001}, "count cells");
		done("count");
		// Sample inputs, toggle outputs an odd number of times
		a_pin_in <= 18'h2A5A5;
		load_chain({DIR_OK, 12'h0, 54'h0, 18'h0F0F0}, rd);
		run_op({18'h0, 3'b100}, 3);
		check({70'h0, core_a_in}, {70'h0, 18'h2A5A5}, "sampled to core");
		check({70'h0, b_pin_out}, {70'h0, 18'h30F0F}, "toggled outputs");
		load_chain({DIR_OK, 12'h0, 18'h2A5A5, 36'h0, 18'h30F0F}, rd);
		check(rd, {DIR_OK, 12'h0, 18'h2A5A5, 36'h0, 18'h30F0F}, "sample cells");
		done("sample");
		// Toggle instruction: outputs flip, inputs ignore pins
		a_pin_in <= 18'h15A5A;
		steps(4'h4, 1);
		check({70'h0, b_pin_out}, {70'h0, 18'h0F0F0}, "toggle outputs");
		check({70'h0, core_a_in}, {70'h0, 18'h2A5A5}, "toggle inputs held");
		done("toggle");
		// No enable cell set, so no legal direction: nothing steps
		load_chain({4'h0, 12'h0, 54'h0, 18'h12345}, rd);
		run_op({18'h3FFFF, 3'b111}, 3);
		load_chain({4'h0, 12'h0, 54'h0, 18'h12345}, rd);
		check(rd, {4'h0, 12'h0, 54'h0, 18'h12345}, "invalid direction");
		done("direction");
		// Zero seed and mask table: zero stays zero unless a live pin folds in
		for (int k = 0; k < 6; k++) begin
			@(posedge ref_clk);
			a_pin_in <= G_PINS[k];
			load_chain({DIR_OK, 84'h0}, rd);
			run_op({G_MASK[k], G_OP[k]}, 4);
			load_chain({DIR_OK, 84'h0}, rd);
			check({87'h0, rd[71:0] == 72'h0}, {87'h0, G_ZERO[k]}, "zero seed or mask");
		end
		done("masks");
		stop_test();
	end
endmodule
